// >>> inc/slave_mode_pkg.sv
package slave_mode_pkg;

    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam logic [3:0] SMC_OFFSET = 4'h0;
    localparam logic [3:0] STATUS_OFFSET = 4'h1;
    localparam logic [15:0] SMC_RESET = 16'h0000;
    localparam logic [15:0] SMC_WRITE_MASK = 16'hfff7;

    // ----------------------------------------
    // slave_mode_control fields
    // ----------------------------------------
    localparam int POL_BIT = 15;
    localparam int ECLKB_BIT = 14;
    localparam int PSC_LSB = 12;
    localparam int FILT_LSB = 8;
    localparam int SYNC_BIT = 7;
    localparam int TSEL_LSB = 4;
    localparam int RSVD_BIT = 3;
    localparam int MODE_LSB = 0;

    // ----------------------------------------
    // status register fields
    // ----------------------------------------
    localparam int FLAG_BIT = 0;
    localparam int TRIG_LVL_BIT = 1;
    localparam int ETR_LVL_BIT = 2;

    // ----------------------------------------
    // slave mode codes
    // ----------------------------------------
    localparam logic [2:0] MODE_OFF = 3'h0;
    localparam logic [2:0] MODE_ENC_A = 3'h1;
    localparam logic [2:0] MODE_ENC_B = 3'h2;
    localparam logic [2:0] MODE_ENC_C = 3'h3;
    localparam logic [2:0] MODE_RESET = 3'h4;
    localparam logic [2:0] MODE_SUSPEND = 3'h5;
    localparam logic [2:0] MODE_TRIGGER = 3'h6;
    localparam logic [2:0] MODE_EXT_CLK = 3'h7;

    // ----------------------------------------
    // trigger input select codes
    // ----------------------------------------
    localparam logic [2:0] TSEL_CH1_EDGE = 3'h4;
    localparam logic [2:0] TSEL_FILT_ONE = 3'h5;
    localparam logic [2:0] TSEL_FILT_TWO = 3'h6;
    localparam logic [2:0] TSEL_EXT = 3'h7;

    // ----------------------------------------
    // filter tables, indexed by filter code
    // ----------------------------------------
    // log2 of the dead-time clock divider
    localparam logic [2:0] FILT_DIV_LOG2 [16] = '{
        3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h1, 3'h2, 3'h2,
        3'h3, 3'h3, 3'h4, 3'h4, 3'h4, 3'h5, 3'h5, 3'h5};
    // consecutive equal samples needed
    localparam logic [3:0] FILT_COUNT [16] = '{
        4'h1, 4'h2, 4'h4, 4'h8, 4'h6, 4'h8, 4'h6, 4'h8,
        4'h6, 4'h8, 4'h5, 4'h6, 4'h8, 4'h5, 4'h6, 4'h8};
    localparam logic [3:0] FILT_OFF = 4'h0;
    localparam logic [3:0] FILT_KERNEL_LAST = 4'h3;

endpackage

// >>> hw/ext_trig_filter_unit.sv
`timescale 1ns/1ps
`default_nettype none

module ext_trig_filter_unit (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic din,
    input wire logic [3:0] filter_code,
    input wire logic dead_time_clock,
    output logic dout
);
    import slave_mode_pkg::*;

    logic [4:0] div_q;
    logic [3:0] run_q;
    logic [4:0] mask;
    logic sample;
    logic [3:0] need;

    // ----------------------------------------
    // sampling strobe
    // ----------------------------------------
    always_comb begin
        mask = 5'((6'h01 << FILT_DIV_LOG2[filter_code]) - 6'h01);
        need = FILT_COUNT[filter_code];
        if (filter_code == FILT_OFF) begin
            sample = dead_time_clock;
        end else if (filter_code <= FILT_KERNEL_LAST) begin
            sample = 1'b1;
        end else begin
            sample = dead_time_clock && ((div_q & mask) == mask);
        end
    end

    // dead-time tick divider
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            div_q <= 5'h00;
        end else if (dead_time_clock) begin
            div_q <= div_q + 5'h01;
        end
    end

    // ----------------------------------------
    // run-length filter
    // ----------------------------------------
    // a new level is taken after need equal samples in a row
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            run_q <= 4'h0;
            dout <= 1'b0;
        end else if (sample) begin
            if (din == dout) begin
                run_q <= 4'h0;
            end else if (run_q + 4'h1 >= need) begin
                run_q <= 4'h0;
                dout <= din;
            end else begin
                run_q <= run_q + 4'h1;
            end
        end
    end

endmodule

`default_nettype wire

// >>> hw/timer_slave_mode_controller.sv
// The implementer's own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module timer_slave_mode_controller (
    input wire logic core_clk,
    input wire logic sys_rst,
    // register port
    input wire logic [slave_mode_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [slave_mode_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [slave_mode_pkg::DATA_W-1:0] reg_rdata,
    // trigger sources
    input wire logic [3:0] internal_source,
    input wire logic chan1_raw_input,
    input wire logic filtered_chan_input_one,
    input wire logic filtered_chan_input_two,
    input wire logic outside_trigger_pin,
    input wire logic dead_time_clock,
    // counter control
    output logic [1:0] encoder_variant,
    output logic counter_reinit,
    output logic counter_run,
    output logic counter_start,
    output logic counter_tick,
    output logic trigger_event,
    output logic master_sync,
    output logic trigger_event_flag
);
    import slave_mode_pkg::*;

    // ----------------------------------------
    // control register
    // ----------------------------------------
    logic [15:0] smc_q;
    logic ext_trig_polarity;
    logic second_ext_clock_enable;
    logic [1:0] ext_trig_prescale;
    logic [3:0] ext_trig_filter;
    logic master_slave_sync_enable;
    logic [2:0] trigger_input_select;
    logic [2:0] slave_mode_select;

    // software writes; reserved bit 3 is forced to zero
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            smc_q <= SMC_RESET;
        end else if (reg_write && reg_addr == SMC_OFFSET) begin
            smc_q <= reg_wdata & SMC_WRITE_MASK;
        end
    end

    // field split
    assign ext_trig_polarity = smc_q[POL_BIT];
    assign second_ext_clock_enable = smc_q[ECLKB_BIT];
    assign ext_trig_prescale = smc_q[PSC_LSB +: 2];
    assign ext_trig_filter = smc_q[FILT_LSB +: 4];
    assign master_slave_sync_enable = smc_q[SYNC_BIT];
    assign trigger_input_select = smc_q[TSEL_LSB +: 3];
    assign slave_mode_select = smc_q[MODE_LSB +: 3];

    // ----------------------------------------
    // external trigger conditioning
    // ----------------------------------------
    logic etr_pol;
    logic etr_pol_q;
    logic [2:0] psc_cnt_q;
    logic etr_div;
    logic etr_div_q;
    logic etr_cond;
    logic etr_cond_q;
    logic etr_cond_rise;

    // polarity: invert when the bit is set
    assign etr_pol = outside_trigger_pin ^ ext_trig_polarity;

    // rising-edge counter feeding the divider
    // the count is kept across a prescale change, so the first divided edge may come early
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            etr_pol_q <= 1'b0;
            psc_cnt_q <= 3'h0;
        end else begin
            etr_pol_q <= etr_pol;
            if (etr_pol && !etr_pol_q) begin
                psc_cnt_q <= psc_cnt_q + 3'h1;
            end
        end
    end

    // divided level: each counter bit halves the edge rate
    always_comb begin
        unique case (ext_trig_prescale)
            2'h0: etr_div = etr_pol_q;
            2'h1: etr_div = psc_cnt_q[0];
            2'h2: etr_div = psc_cnt_q[1];
            2'h3: etr_div = psc_cnt_q[2];
        endcase
    end

    // divided level register, keeps the divider mux off the filter input
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            etr_div_q <= 1'b0;
        end else begin
            etr_div_q <= etr_div;
        end
    end

    // digital filter on the divided trigger
    ext_trig_filter_unit filter_inst (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .din(etr_div_q),
        .filter_code(ext_trig_filter),
        .dead_time_clock(dead_time_clock),
        .dout(etr_cond)
    );

    // previous conditioned level, for rising-edge detection
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            etr_cond_q <= 1'b0;
        end else begin
            etr_cond_q <= etr_cond;
        end
    end

    assign etr_cond_rise = etr_cond && !etr_cond_q;

    // ----------------------------------------
    // trigger input selection
    // ----------------------------------------
    logic ch1_q;
    logic chan1_edge_detect;
    logic slave_trigger_input;
    logic trig_q;
    logic trig_rise;
    logic trig_any;

    // channel 1 raw input edge detector, pulses on either edge
    // resets low like the idle pin, so no false edge follows reset
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ch1_q <= 1'b0;
        end else begin
            ch1_q <= chan1_raw_input;
        end
    end

    assign chan1_edge_detect = chan1_raw_input ^ ch1_q;

    // source multiplexer
    always_comb begin
        if (!trigger_input_select[2]) begin
            // codes 000-011 pick internal sources 0-3
            // code 001 falls in the same index path as the others
            slave_trigger_input = internal_source[trigger_input_select[1:0]];
        end else begin
            unique case (trigger_input_select)
                TSEL_CH1_EDGE: slave_trigger_input = chan1_edge_detect;
                TSEL_FILT_ONE: slave_trigger_input = filtered_chan_input_one;
                TSEL_FILT_TWO: slave_trigger_input = filtered_chan_input_two;
                TSEL_EXT: slave_trigger_input = etr_cond;
                default: slave_trigger_input = 1'b0;
            endcase
        end
    end

    // previous trigger sample, for edge detection
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            trig_q <= 1'b0;
        end else begin
            trig_q <= slave_trigger_input;
        end
    end

    assign trig_rise = slave_trigger_input && !trig_q;
    assign trig_any = slave_trigger_input ^ trig_q;

    // ----------------------------------------
    // slave mode actions
    // ----------------------------------------
    logic is_suspend;
    logic is_encoder;
    logic is_reset_mode;
    logic is_trigger_mode;
    logic is_ext_clock_mode;
    logic trig_evt;

    // one decode of the slave mode field, shared by every action below but the master sync request
    assign is_suspend = slave_mode_select == MODE_SUSPEND;
    assign is_encoder = slave_mode_select == MODE_ENC_A
        || slave_mode_select == MODE_ENC_B
        || slave_mode_select == MODE_ENC_C;
    assign is_reset_mode = slave_mode_select == MODE_RESET;
    assign is_trigger_mode = slave_mode_select == MODE_TRIGGER;
    assign is_ext_clock_mode = slave_mode_select == MODE_EXT_CLK;
    // active edge, or either edge while suspended
    assign trig_evt = is_suspend ? trig_any : trig_rise;

    // encoder variant: 0 when not in an encoder mode
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            encoder_variant <= 2'h0;
        end else if (is_encoder) begin
            encoder_variant <= slave_mode_select[1:0];
        end else begin
            encoder_variant <= 2'h0;
        end
    end

    // counter reinit pulse
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            counter_reinit <= 1'b0;
        end else begin
            counter_reinit <= is_reset_mode && trig_rise;
        end
    end

    // counting gate: suspend follows the trigger level
    // outside suspend this block never holds the counter
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            counter_run <= 1'b1;
        end else if (is_suspend) begin
            counter_run <= slave_trigger_input;
        end else begin
            counter_run <= 1'b1;
        end
    end

    // counter start pulse in trigger mode
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            counter_start <= 1'b0;
        end else begin
            counter_start <= is_trigger_mode && trig_rise;
        end
    end

    logic tick_mode_a;
    logic tick_mode_b;

    // mode A counts rising edges of the selected trigger
    assign tick_mode_a = is_ext_clock_mode && trig_rise;
    // mode B counts rising edges of the conditioned external trigger,
    // whatever the slave mode field holds
    assign tick_mode_b = second_ext_clock_enable && etr_cond_rise;

    // external clock ticks: either source advances the counter
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            counter_tick <= 1'b0;
        end else begin
            counter_tick <= tick_mode_a || tick_mode_b;
        end
    end

    // trigger event pulse
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            trigger_event <= 1'b0;
        end else begin
            trigger_event <= trig_evt;
        end
    end

    // synchronization request towards the master timer
    // the enable is only handed on; the master side acts on it
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            master_sync <= 1'b0;
        end else begin
            master_sync <= master_slave_sync_enable;
        end
    end

    // ----------------------------------------
    // trigger flag and status
    // ----------------------------------------
    logic flag_clear;

    // writing zero to the flag bit clears it
    // writing one leaves the flag alone
    assign flag_clear = reg_write && reg_addr == STATUS_OFFSET && !reg_wdata[FLAG_BIT];

    // a new event beats a clear in the same cycle
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            trigger_event_flag <= 1'b0;
        end else if (trig_evt) begin
            trigger_event_flag <= 1'b1;
        end else if (flag_clear) begin
            trigger_event_flag <= 1'b0;
        end
    end

    // ----------------------------------------
    // read port
    // ----------------------------------------
    logic [15:0] status_word;

    // status bits; unused bits read as zero
    always_comb begin
        status_word = 16'h0000;
        status_word[FLAG_BIT] = trigger_event_flag;
        status_word[TRIG_LVL_BIT] = trig_q;
        status_word[ETR_LVL_BIT] = etr_cond_q;
    end

    // read data one cycle after the strobe, zero otherwise
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_read && reg_addr == SMC_OFFSET) begin
            reg_rdata <= smc_q;
        end else if (reg_read && reg_addr == STATUS_OFFSET) begin
            reg_rdata <= status_word;
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

endmodule

`default_nettype wire

// >>> test/trig_partner.sv
`timescale 1ns/1ps
`default_nettype none

// ---
// far side: master sources, channel 1 inputs, trigger pin
// ---
module trig_partner (
    input wire logic core_clk,
    output logic [3:0] internal_source,
    output logic chan1_raw_input,
    output logic filtered_chan_input_one,
    output logic filtered_chan_input_two,
    output logic outside_trigger_pin,
    output logic dead_time_clock
);
    logic [7:0] lines = 8'h00;
    // line i matches trigger select code i
    assign {outside_trigger_pin, filtered_chan_input_two} = lines[7:6];
    assign {filtered_chan_input_one, chan1_raw_input} = lines[5:4];
    assign internal_source = lines[3:0];
    logic tick_q = 1'b0;
    // dead-time tick every second kernel cycle, so that kernel-rate
    // and dead-time-rate sampling differ
    always @(posedge core_clk) begin
        tick_q <= ~tick_q;
    end
    assign dead_time_clock = tick_q;
    // levels move only just after a rising edge
    task automatic set(input int i, input logic v);
        @(posedge core_clk);
        lines[i] <= v;
    endtask
    // one line high for w cycles
    task automatic pulse(input int i, input int w);
        set(i, 1'b1);
        repeat (w - 1) @(posedge core_clk);
        set(i, 1'b0);
    endtask
endmodule

`default_nettype wire

// >>> test/timer_slave_mode_checker.sv
`timescale 1ns/1ps
`default_nettype none

module timer_slave_mode_checker (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [slave_mode_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [slave_mode_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [slave_mode_pkg::DATA_W-1:0] reg_rdata,
    input wire logic [3:0] internal_source,
    input wire logic filtered_chan_input_one,
    input wire logic filtered_chan_input_two,
    input wire logic [1:0] encoder_variant,
    input wire logic counter_reinit,
    input wire logic counter_run,
    input wire logic counter_start,
    input wire logic counter_tick,
    input wire logic trigger_event,
    input wire logic master_sync,
    input wire logic trigger_event_flag
);
    import slave_mode_pkg::*;
    logic [15:0] ctrl_q;
    logic [1:0] quiet_q;
    logic [2:0] mode;
    logic [2:0] tsel;
    logic trig;
    logic act;
    // ---
    // control shadow and cycles since its last write
    // ---
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ctrl_q <= SMC_RESET;
            quiet_q <= 2'h0;
        end else if (reg_write && reg_addr == SMC_OFFSET) begin
            ctrl_q <= reg_wdata & SMC_WRITE_MASK;
            quiet_q <= 2'h0;
        end else if (quiet_q != 2'h3) begin
            quiet_q <= quiet_q + 2'h1;
        end
    end
    // selected trigger, for the sources known here
    assign mode = ctrl_q[2:0];
    assign tsel = ctrl_q[6:4];
    assign trig = tsel[2] ? (tsel[0] ? filtered_chan_input_one : filtered_chan_input_two)
        : internal_source[tsel[1:0]];
    assign act = quiet_q == 2'h3 && tsel != TSEL_CH1_EDGE && tsel != TSEL_EXT;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);
    ctrl_read_a: assert property (reg_read && reg_addr == SMC_OFFSET |=>
        reg_rdata == ctrl_q) else $error("control read wrong");
    sync_copy_a: assert property ($stable(ctrl_q) |->
        master_sync == ctrl_q[SYNC_BIT]) else $error("sync output wrong");
    enc_map_a: assert property ($stable(ctrl_q) |-> encoder_variant ==
        (mode inside {[1:3]} ? mode[1:0] : 2'h0)) else $error("encoder variant wrong");
    reinit_edge_a: assert property (act && mode == MODE_RESET && $rose(trig) |=>
        counter_reinit) else $error("no reinit");
    run_level_a: assert property (act && mode == MODE_SUSPEND |=>
        counter_run == $past(trig)) else $error("run not following trigger");
    run_free_a: assert property (quiet_q == 2'h3 && mode != MODE_SUSPEND |->
        counter_run) else $error("run low outside suspend");
    start_edge_a: assert property (act && mode == MODE_TRIGGER && $rose(trig) |=>
        counter_start && trigger_event) else $error("no start");
    tick_edge_a: assert property (act && mode == MODE_EXT_CLK && $rose(trig) |=>
        counter_tick) else $error("no tick");
    flag_any_a: assert property (act && mode == MODE_SUSPEND && $changed(trig) |=>
        trigger_event_flag) else $error("flag not set");
    flag_hold_a: assert property (trigger_event_flag && !reg_write |=>
        trigger_event_flag) else $error("flag lost");
endmodule

bind timer_slave_mode_controller timer_slave_mode_checker chk (.*);

`default_nettype wire

// >>> test/tb_timer_slave_mode_controller.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin \
    samples_checked++; \
    if ((g) !== (e)) begin \
        num_errors++; \
        $display("MISMATCH t=%0t got %0h exp %0h", $time, g, e); \
    end \
end

module tb_timer_slave_mode_controller;
    import slave_mode_pkg::*;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [15:0] reg_rdata, rd;
    logic [3:0] internal_source;
    logic chan1_raw_input, filtered_chan_input_one, filtered_chan_input_two;
    logic outside_trigger_pin, dead_time_clock, master_sync, trigger_event_flag;
    logic [1:0] encoder_variant;
    logic counter_reinit, counter_run, counter_start, counter_tick, trigger_event;
    int num_errors = 0;
    int samples_checked = 0;
    int n_re, n_st, n_tk;
    timer_slave_mode_controller dut (.*);
    trig_partner p (.*);
    // ---
    // clock, pulse counters, bus tasks
    // ---
    initial begin
        forever #10 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        n_re += counter_reinit;
        n_st += counter_start;
        n_tk += counter_tick;
    end
    task automatic tk(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge core_clk);
        reg_write <= 1'b0;
    endtask
    task automatic rdc(input logic [3:0] a, output logic [15:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge core_clk);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // write control, let it settle, zero the counters
    task automatic cfg(input logic [15:0] v);
        wr(SMC_OFFSET, v);
        tk(40);
        @(negedge core_clk);
        n_re = 0;
        n_st = 0;
        n_tk = 0;
    endtask
    task automatic t_regs();
        rdc(SMC_OFFSET, rd);
        `CHK(rd, SMC_RESET)
        wr(SMC_OFFSET, 16'hfff7);
        rdc(SMC_OFFSET, rd);
        `CHK(rd, 16'hfff7)
        `CHK(master_sync, 1'b1)
        rdc(4'h9, rd);
        `CHK(rd, 16'h0000)
        for (int m = 0; m < 4; m++) begin
            wr(SMC_OFFSET, 16'(m));
            tk(2);
            `CHK(encoder_variant, 2'(m))
            `CHK(master_sync, 1'b0)
        end
        $display("registers done");
    endtask
    task automatic t_sel();
        for (int c = 0; c < 8; c++) begin
            cfg(16'(c * 16 + 6));
            p.pulse((c + 1) % 8, 6);
            p.pulse(c, 6);
            tk(20);
            `CHK(n_st > 0, 1'b1)
            `CHK(n_st, (c == 4) ? 2 : 1)
        end
        wr(STATUS_OFFSET, 16'h0000);
        rdc(STATUS_OFFSET, rd);
        `CHK(rd[FLAG_BIT], 1'b0)
        $display("select done");
    endtask
    task automatic t_modes();
        cfg(16'h0004);
        repeat (3) p.pulse(0, 3);
        tk(8);
        `CHK(n_re, 3)
        `CHK(n_st, 0)
        `CHK(counter_run, 1'b1)
        cfg(16'h0007);
        repeat (3) p.pulse(0, 3);
        tk(8);
        `CHK(n_tk, 3)
        cfg(16'h0005);
        `CHK(counter_run, 1'b0)
        p.set(0, 1'b1);
        tk(3);
        `CHK(counter_run, 1'b1)
        wr(STATUS_OFFSET, 16'h0000);
        p.set(0, 1'b0);
        tk(3);
        `CHK(counter_run, 1'b0)
        rdc(STATUS_OFFSET, rd);
        `CHK(rd[FLAG_BIT], 1'b1)
        $display("modes done");
    endtask
    task automatic t_ext();
        for (int v = 0; v < 2; v++) begin
            cfg(16'(v * 32768 + 16'h4100));
            rdc(STATUS_OFFSET, rd);
            `CHK(rd[ETR_LVL_BIT], v[0])
            p.set(7, 1'b1);
            tk(15);
            `CHK(n_tk, 1 - v)
            p.set(7, 1'b0);
            tk(15);
            `CHK(n_tk, 1)
        end
        cfg(16'h0100);
        p.pulse(7, 6);
        tk(15);
        `CHK(n_tk, 0)
        for (int s = 0; s < 4; s++) begin
            cfg(16'(s * 4096 + 16'h4100));
            repeat (8) begin
                p.pulse(7, 4);
                tk(3);
            end
            tk(20);
            `CHK(n_tk, 8 >> s)
        end
        $display("external done");
    endtask
    // a run one sample short is dropped, a full run passes
    task automatic t_flt();
        int fc [6] = '{0, 1, 2, 3, 4, 15};
        int lo [6] = '{0, 1, 3, 7, 20, 448};
        int hi [6] = '{2, 2, 4, 8, 28, 576};
        for (int i = 0; i < 6; i++) begin
            cfg(16'(fc[i] * 256 + 16'h4000));
            if (lo[i] > 0) p.pulse(7, lo[i]);
            tk(2 * hi[i] + 40);
            `CHK(n_tk, 0)
            p.pulse(7, hi[i]);
            tk(2 * hi[i] + 40);
            `CHK(n_tk, 1)
        end
        $display("filter done");
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge core_clk);
        sys_rst <= 1'b0;
        t_regs();
        t_sel();
        t_modes();
        t_ext();
        t_flt();
        print_verdict();
    end
    initial begin
        repeat (30000) @(posedge core_clk);
        num_errors++;
        print_verdict();
    end
endmodule

`default_nettype wire
